// ===== inc/atten_shift_pkg.sv
/*
 * Constants shared by the serial attenuator control shifter.
 * Assumes a system clock of 250 MHz and a serial clock made by an outside controller.
 */
// Functional notes
// - Each rising serial clock edge captures the serial input; controller sends LSB first.
// - Rising load strobe copies the five most recent shifted bits to attenuation outputs.
// - Serial output repeats the serial input exactly eight serial clocks later.
// - Reset input low clears every shift stage regardless of clock and strobe.
// - Reset input low returns all attenuation outputs to the zero-attenuation code.
// - Attenuation code is binary weighted, 0.5 dB per LSB, 15.5 dB at all ones.
package atten_shift_pkg;

	localparam int unsigned SHIFT_DEPTH     = 8;
	localparam int unsigned ATTEN_BITS      = 5;
	localparam int unsigned SYNC_STAGES     = 3;
	localparam int unsigned ATTEN_CTRL_LSB  = 0;
	localparam int unsigned ATTEN_CTRL_MSB  = ATTEN_BITS - 1;
	localparam int unsigned CDB_WIDTH       = 11;
	localparam logic [10:0] STEP_CENTI_DB   = 11'h032;
	localparam logic [4:0]  ATTEN_ZERO      = 5'h00;
	localparam logic [4:0]  ATTEN_ALL_ONES  = 5'h1F;
	localparam logic [10:0] CDB_ZERO        = 11'h000;
	localparam logic [7:0]  SHIFT_CLEAR     = 8'h00;
	localparam logic [3:0]  FILL_FULL       = 4'h8;
	localparam logic [3:0]  FILL_ZERO       = 4'h0;

	// Strobe setup times the controller keeps; the sync path relies on them
	localparam int unsigned SYS_CLK_PERIOD_NS  = 4;
	localparam int unsigned STROBE_SETUP_NS    = 40;
	localparam int unsigned STROBE_SETUP_CYC   =
		(STROBE_SETUP_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

endpackage

// ===== rtl/sync_agree.sv
/*
 * Three-flop synchroniser bank with agreement filter.
 * Assumes asynchronous inputs; output updates per bit once stages two and three agree.
 */
module sync_agree
	import atten_shift_pkg::*;
#(
	parameter int unsigned     WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
	input  wire logic             i_sys_clk,
	input  wire logic             i_srst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_level
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] mid_reg;
	logic [WIDTH-1:0] last_reg;
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] level_next;

	// First stage feeds only the second stage
	always_comb
	begin
		level_next = (last_reg & ~(mid_reg ^ last_reg)) | (level_reg & (mid_reg ^ last_reg));
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			meta_reg  <= RESET_VAL;
			mid_reg   <= RESET_VAL;
			last_reg  <= RESET_VAL;
			level_reg <= RESET_VAL;
		end
		else
		begin
			meta_reg  <= i_async;
			mid_reg   <= meta_reg;
			last_reg  <= mid_reg;
			level_reg <= level_next;
		end
	end

	assign o_level = level_reg;

endmodule

// ===== rtl/atten_shift_ctrl.sv
/*
 * Serial-to-parallel control shifter for a five-bit step attenuator.
 * Assumes the controller keeps strobe and reset setup times, so shifted data is
 * quiescent while the strobe edge crosses into the system clock domain.
 */
module atten_shift_ctrl
	import atten_shift_pkg::*;
(
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_srst,
	input  wire logic                  i_ser_clk,
	input  wire logic                  i_ser_data,
	input  wire logic                  i_load_strobe_pin,
	input  wire logic                  i_reset_n,
	output logic                       o_ser_out,
	output logic      [ATTEN_BITS-1:0] o_atten_ctrl,
	output logic      [CDB_WIDTH-1:0]  o_atten_centi_db
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Newest bit is the MSB because the controller sends LSB first
	function automatic logic [ATTEN_BITS-1:0] newest_to_code(input logic [SHIFT_DEPTH-1:0] sr);
		logic [ATTEN_BITS-1:0] code;
		code = ATTEN_ZERO;
		for (int i = 0; i < ATTEN_BITS; i++)
		begin
			code[i] = sr[ATTEN_BITS-1-i];
		end
		return code;
	endfunction

	function automatic logic [CDB_WIDTH-1:0] code_to_centi_db(input logic [ATTEN_BITS-1:0] code);
		logic [CDB_WIDTH-1:0] wide;
		wide = {{(CDB_WIDTH-ATTEN_BITS){1'b0}}, code};
		return CDB_WIDTH'(wide * STEP_CENTI_DB);
	endfunction

	// ------------------------------------------------------------
	// Link domain: shift register on the serial clock
	// ------------------------------------------------------------

	logic [SHIFT_DEPTH-1:0] sr_reg;
	logic [SHIFT_DEPTH-1:0] sr_next;

	always_comb
	begin
		sr_next = {sr_reg[SHIFT_DEPTH-2:0], i_ser_data};
	end

	// Asynchronous clear: the serial clock may be stopped while reset is low
	always_ff @(posedge i_ser_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			sr_reg <= SHIFT_CLEAR;
		end
		else
		begin
			sr_reg <= sr_next;
		end
	end

	assign o_ser_out = sr_reg[SHIFT_DEPTH-1];

	// ------------------------------------------------------------
	// Crossing into the system domain
	// ------------------------------------------------------------

	// Data bits are static well before the strobe rises, so per-bit sync is safe;
	// a strobe closer than the sync latency to the last shift edge may load stale bits
	logic [ATTEN_BITS-1:0] code_async;
	logic [ATTEN_BITS-1:0] code_filt;
	logic                  strobe_filt;
	logic                  rst_n_filt;

	assign code_async = newest_to_code(sr_reg);

	sync_agree #(
		.WIDTH     (ATTEN_BITS),
		.RESET_VAL (ATTEN_ZERO)
	) u_sync_code (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_async   (code_async),
		.o_level   (code_filt)
	);

	sync_agree #(
		.WIDTH     (2),
		.RESET_VAL (2'h0)
	) u_sync_ctrl (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_async   ({i_load_strobe_pin, i_reset_n}),
		.o_level   ({strobe_filt, rst_n_filt})
	);

	// ------------------------------------------------------------
	// System domain: attenuation latch
	// ------------------------------------------------------------

	logic                  strobe_prev_reg;
	logic                  strobe_prev_next;
	logic [ATTEN_BITS-1:0] atten_reg;
	logic [ATTEN_BITS-1:0] atten_next;
	logic [CDB_WIDTH-1:0]  cdb_reg;
	logic [CDB_WIDTH-1:0]  cdb_next;
	logic                  strobe_rise;

	assign strobe_rise = strobe_filt & ~strobe_prev_reg;

	always_comb
	begin
		strobe_prev_next = strobe_filt;
		atten_next       = atten_reg;
		if (!rst_n_filt)
		begin
			atten_next = ATTEN_ZERO;
		end
		else if (strobe_rise)
		begin
			atten_next = code_filt;
		end
		cdb_next = code_to_centi_db(atten_reg);
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			strobe_prev_reg <= 1'b0;
			atten_reg       <= ATTEN_ZERO;
			cdb_reg         <= CDB_ZERO;
		end
		else
		begin
			strobe_prev_reg <= strobe_prev_next;
			atten_reg       <= atten_next;
			cdb_reg         <= cdb_next;
		end
	end

	assign o_atten_ctrl     = atten_reg;
	assign o_atten_centi_db = cdb_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------

	// Edges seen since reset release, saturating at the shift depth
	logic [3:0] fill_reg;
	logic [3:0] fill_next;

	always_comb
	begin
		fill_next = (fill_reg == FILL_FULL) ? fill_reg : 4'(fill_reg + 4'h1);
	end

	always_ff @(posedge i_ser_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			fill_reg <= FILL_ZERO;
		end
		else
		begin
			fill_reg <= fill_next;
		end
	end

	property p_capture;
		@(posedge i_ser_clk) disable iff (!i_reset_n)
		(fill_reg != FILL_ZERO) |-> sr_reg[0] == $past(i_ser_data);
	endproperty
	a_capture: assert property (p_capture) else $error("Serial bit not captured");

	property p_ser_delay;
		@(posedge i_ser_clk) disable iff (!i_reset_n)
		(fill_reg == FILL_FULL) |-> o_ser_out == $past(i_ser_data, 8);
	endproperty
	a_ser_delay: assert property (p_ser_delay) else $error("Serial out not delayed by eight");

	property p_clear;
		@(posedge i_sys_clk) disable iff (i_srst)
		!i_reset_n |-> (sr_reg == SHIFT_CLEAR && o_ser_out == 1'b0);
	endproperty
	a_clear: assert property (p_clear) else $error("Shift register not cleared");

	property p_reset_zero;
		@(posedge i_sys_clk) disable iff (i_srst)
		(!i_reset_n) [*6] |-> o_atten_ctrl == ATTEN_ZERO ##1 o_atten_centi_db == CDB_ZERO;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("Reset did not zero attenuation");

	property p_load;
		@(posedge i_sys_clk) disable iff (i_srst)
		(strobe_rise && rst_n_filt) |=> o_atten_ctrl == $past(code_filt);
	endproperty
	a_load: assert property (p_load) else $error("Strobe did not load code");

	property p_hold;
		@(posedge i_sys_clk) disable iff (i_srst)
		(!strobe_rise && rst_n_filt) |=> $stable(o_atten_ctrl);
	endproperty
	a_hold: assert property (p_hold) else $error("Attenuation changed without strobe");

	property p_weight;
		@(posedge i_sys_clk) disable iff (i_srst)
		$changed(o_atten_ctrl)
			|=> o_atten_centi_db == STEP_CENTI_DB * CDB_WIDTH'($past(o_atten_ctrl))
			##1 o_atten_centi_db == STEP_CENTI_DB * CDB_WIDTH'($past(o_atten_ctrl));
	endproperty
	a_weight: assert property (p_weight) else $error("Attenuation weight wrong");

	property p_lsb_stage;
		@(posedge i_sys_clk) disable iff (i_srst || !i_reset_n)
		(strobe_rise && rst_n_filt && code_filt == code_async)
			|=> o_atten_ctrl[ATTEN_CTRL_LSB] == $past(sr_reg[ATTEN_BITS-1]);
	endproperty
	a_lsb_stage: assert property (p_lsb_stage) else $error("LSB not from fifth stage");

	c_load_max: cover property (@(posedge i_sys_clk) disable iff (i_srst)
		strobe_rise ##1 o_atten_ctrl == ATTEN_ALL_ONES);
	c_load_lsb: cover property (@(posedge i_sys_clk) disable iff (i_srst)
		strobe_rise ##1 o_atten_ctrl == 5'h01);
	c_reset_after_load: cover property (@(posedge i_sys_clk) disable iff (i_srst)
		o_atten_ctrl != ATTEN_ZERO ##1 !i_reset_n [*6] ##1 o_atten_ctrl == ATTEN_ZERO);
	c_chain_out: cover property (@(posedge i_ser_clk) disable iff (!i_reset_n)
		fill_reg == FILL_FULL && o_ser_out);

endmodule

// ===== verification/atten_host_model.sv
/*
 * Host controller model: serial clock, serial data, load strobe and reset pin.
 * Assumes the bench calls its tasks one at a time; serial clock idles low between frames.
 */
module atten_host_model
(
	output logic o_ser_clk,
	output logic o_ser_data,
	output logic o_load_strobe_pin,
	output logic o_reset_n
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		o_ser_clk = 1'b0;
		o_ser_data = 1'b0;
		o_load_strobe_pin = 1'b0;
		o_reset_n = 1'b1;
	end

	// Data flips once its hold time is over, so a late sample sees the inverted bit
	task automatic send_bit(input logic b);
		o_ser_data = b;
		#32 o_ser_clk = 1'b1;
		#5 o_ser_data = ~b;
		#27 o_ser_clk = 1'b0;
	endtask

	task automatic strobe;
		#40 o_load_strobe_pin = 1'b1;
		#80 o_load_strobe_pin = 1'b0;
		#20;
	endtask

	task automatic set_reset_n(input logic lvl);
		o_reset_n = lvl;
		#60;
	endtask
endmodule

// ===== verification/atten_shift_ctrl_tb.sv
/*
 * Self-checking bench for the attenuator control shifter.
 * Assumes the host model keeps the link timing; system clock 250 MHz.
 */
module atten_shift_ctrl_tb
	import atten_shift_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                  sys_clk = 1'b0;
	logic                  srst = 1'b1;
	logic                  ser_clk, ser_data, strobe_pin, reset_n, ser_out;
	logic [ATTEN_BITS-1:0] atten;
	logic [ATTEN_BITS-1:0] chain_atten;
	logic [CDB_WIDTH-1:0]  centi;
	int                    compares = 0;
	int                    miscompares = 0;

	always #2 sys_clk = ~sys_clk;

	atten_host_model host (.o_ser_clk(ser_clk), .o_ser_data(ser_data),
		.o_load_strobe_pin(strobe_pin), .o_reset_n(reset_n));

	atten_shift_ctrl uut (.i_sys_clk(sys_clk), .i_srst(srst), .i_ser_clk(ser_clk),
		.i_ser_data(ser_data), .i_load_strobe_pin(strobe_pin), .i_reset_n(reset_n),
		.o_ser_out(ser_out), .o_atten_ctrl(atten), .o_atten_centi_db(centi));

	// Second device in a cascade, fed from the first one's serial output
	atten_shift_ctrl uut_next (.i_sys_clk(sys_clk), .i_srst(srst), .i_ser_clk(ser_clk),
		.i_ser_data(ser_out), .i_load_strobe_pin(strobe_pin), .i_reset_n(reset_n),
		.o_ser_out(), .o_atten_ctrl(chain_atten), .o_atten_centi_db());

	// ----------------------------------------
	// Checks and verdict
	// ----------------------------------------
	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: serial out %b, expected %b", $time, got, exp);
		end
	endtask

	task automatic chk_word(input logic [10:0] got, input logic [10:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic results;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_codes;
		logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h1F, 5'h15, 5'h0A};
		foreach (codes[n])
		begin
			for (int i = 0; i < 5; i++)
				host.send_bit(codes[n][i]);
			host.strobe();
			chk_word({6'h00, atten}, {6'h00, codes[n]});
			chk_word(centi, {6'h00, codes[n]} * STEP_CENTI_DB);
		end
		$display("codes test done");
	endtask

	// Clock edges while the pin is low must not refill the register
	task automatic test_reset_pin;
		for (int i = 0; i < 8; i++)
			host.send_bit(1'b1);
		chk_bit(ser_out, 1'b1);
		host.set_reset_n(1'b0);
		chk_bit(ser_out, 1'b0);
		host.send_bit(1'b1);
		chk_bit(ser_out, 1'b0);
		chk_word({6'h00, atten}, {6'h00, ATTEN_ZERO});
		chk_word(centi, CDB_ZERO);
		host.set_reset_n(1'b1);
		$display("reset pin test done");
	endtask

	// Sixteen bits: output lags input by eight, then only the newest five load
	task automatic test_delay_chain;
		logic [15:0] word = 16'hB5C3;
		logic [7:0]  hist = 8'h00;
		for (int k = 0; k < 16; k++)
		begin
			host.send_bit(word[k]);
			hist = {hist[6:0], word[k]};
			chk_bit(ser_out, hist[7]);
		end
		host.strobe();
		chk_word({6'h00, atten}, {6'h00, word[15:11]});
		chk_word({6'h00, chain_atten}, {6'h00, word[7:3]});
		$display("delay chain test done");
	endtask

	initial
	begin
		repeat (8) @(negedge sys_clk);
		srst = 1'b0;
		// Shift stages power up unknown until the pin clears them
		host.set_reset_n(1'b0);
		host.set_reset_n(1'b1);
		repeat (6) @(negedge sys_clk);
		chk_bit(ser_out, 1'b0);
		chk_word({6'h00, atten}, {6'h00, ATTEN_ZERO});
		test_codes();
		test_reset_pin();
		test_delay_chain();
		results();
	end

	initial
	begin
		#100000;
		miscompares++;
		results();
	end
endmodule
